//--- ptm_consts.svh
// frame geometry and fixed words for the tributary multiplexer
`ifndef PTM_CONSTS_SVH
`define PTM_CONSTS_SVH
// ****************************************
// frame geometry
// ****************************************
`define PTM_E2_SET_LEN 9'd212
`define PTM_E3_SET_LEN 9'd384
`define PTM_G_SET_LEN 9'd168
`define PTM_E_SETS 3'd4
`define PTM_G_SETS 3'd5
`define PTM_E_TRIBS 2'd3
`define PTM_G_TRIBS 2'd2
// ****************************************
// overhead positions
// ****************************************
`define PTM_E_ALIGN 10'h3d0
`define PTM_G_ALIGN 9'h1d0
`define PTM_E_ALIGN_LEN 9'd10
`define PTM_G_ALIGN_LEN 9'd9
`define PTM_E_STUFF_POS 9'd4
`define PTM_G_STUFF_POS 9'd3
`endif

//--- ptm_line_model.sv
// line-side loopback partner: returns every transmitted line bit on the strobed receive pins
`timescale 1ns/1ps
module ptm_line_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_data,
    input wire logic tx_valid,
    output logic rx_data = 1'b0,
    output logic rx_strobe = 1'b0,
    output logic busy = 1'b0
);
    logic fifo [$]; // bits waiting to go back to the receiver
    logic [1:0] phase = 2'h0; // strobe phase of the bit in flight
    logic active = 1'b0; // a bit is on the data pin
    // ****************************************
    // strobed return path
    // ****************************************
    // four cycles a bit, slower than the transmitter, so the queue really fills
    always @(posedge clk) begin
        if (rst) begin
            fifo.delete();
            active <= 1'b0;
            phase <= 2'h0;
            rx_strobe <= 1'b0;
            busy <= 1'b0;
        end else begin
            if (tx_valid === 1'b1) begin
                fifo.push_back(tx_data);
            end
            if (!active && fifo.size() != 0) begin
                // data settles a cycle before the strobe rises
                rx_data <= fifo.pop_front();
                active <= 1'b1;
                phase <= 2'h0;
            end else if (active) begin
                phase <= phase + 2'h1;
                rx_strobe <= (phase != 2'h2);
                if (phase == 2'h2) begin
                    // released pin shows the inverse, never the stale value
                    active <= 1'b0;
                    rx_data <= ~rx_data;
                end
            end
            busy <= active || (fifo.size() != 0) || (tx_valid === 1'b1);
        end
    end
endmodule

//--- ptm_mux.sv
// tributary bit-interleave framer and deframer, one stage
`timescale 1ns/1ps
`include "ptm_consts.svh"
module ptm_mux (
    input wire logic clk,
    input wire logic rst,
    input wire ptm_pkg::ptm_mode_t mode,
    input wire logic tx_bit_en,
    input wire logic tx_rai,
    input wire logic tx_nat,
    input wire logic [3:0] trib_stuff_req,
    input wire logic [3:0] trib_tx_data,
    output logic [3:0] trib_tx_rd,
    output logic line_tx_data,
    output logic line_tx_valid,
    output logic line_tx_frame_start,
    input wire logic line_rx_data,
    input wire logic line_rx_strobe,
    output logic [3:0] trib_rx_data,
    output logic [3:0] trib_rx_valid,
    output logic rx_in_frame,
    output logic rx_rai,
    output logic rx_nat,
    output logic rx_parity_err
);
    import ptm_pkg::*;

    // ****************************************
    // frame geometry helpers
    // ****************************************
    // one stage per framing; an e13 chain is two instances in series
    logic is_g;
    logic [8:0] set_len;
    logic [2:0] last_set;
    logic [1:0] last_trib;
    assign is_g = (mode == PTM_G747);
    assign set_len = is_g ? `PTM_G_SET_LEN : (mode == PTM_SECOND_THIRD) ? `PTM_E3_SET_LEN : `PTM_E2_SET_LEN;
    assign last_set = is_g ? `PTM_G_SETS - 3'd1 : `PTM_E_SETS - 3'd1;
    assign last_trib = is_g ? `PTM_G_TRIBS : `PTM_E_TRIBS;

    // classify a slot by set and bit index (both zero based)
    function automatic ptm_kind_t slot(input logic g, input logic [2:0] s, input logic [8:0] b);
        ptm_kind_t k;
        k = K_DAT;
        if (g) begin
            if (s == 3'd0 && b < `PTM_G_ALIGN_LEN) k = K_ALIGN;
            else if (s == 3'd1 && b == 9'd0) k = K_ALARM;
            else if (s == 3'd1 && b == 9'd1) k = K_PARITY;
            else if (s == 3'd1 && b == 9'd2) k = K_ONE;
            else if (s >= 3'd2 && b < 9'd3) k = K_JCB;
            else if (s == 3'd4 && b < 9'd6) k = K_STF;
        end else begin
            if (s == 3'd0 && b < `PTM_E_ALIGN_LEN) k = K_ALIGN;
            else if (s == 3'd0 && b == 9'd10) k = K_ALARM;
            else if (s == 3'd0 && b == 9'd11) k = K_NAT;
            else if (s != 3'd0 && b < 9'd4) k = K_JCB;
            else if (s == 3'd3 && b < 9'd8) k = K_STF;
        end
        return k;
    endfunction

    // ****************************************
    // transmit framer
    // ****************************************
    logic [2:0] tx_set; // current set
    logic [8:0] tx_bit; // bit inside set
    logic [1:0] tx_ptr; // next tributary in rotation
    logic [3:0] stuff_now; // justification latched for this frame
    logic parity_acc; // running parity of tributary bits
    logic parity_prev; // parity of the frame before
    ptm_kind_t tx_kind;
    logic [1:0] tx_trib;
    logic tx_take;
    logic tx_last_bit;
    logic next_bit;

    assign tx_kind = slot(is_g, tx_set, tx_bit);
    assign tx_last_bit = (tx_bit == set_len - 9'd1);
    // fixed slots belong to a fixed tributary, data slots rotate
    always_comb begin
        tx_trib = tx_ptr;
        if (tx_kind == K_JCB) tx_trib = tx_bit[1:0];
        else if (tx_kind == K_STF) tx_trib = is_g ? 2'(tx_bit - `PTM_G_STUFF_POS) : 2'(tx_bit - `PTM_E_STUFF_POS);
    end
    // a stuffed slot takes no tributary bit
    assign tx_take = tx_bit_en && (tx_kind == K_DAT || (tx_kind == K_STF && !stuff_now[tx_trib]));
    // read strobe doubles as the ready for trib_tx_data
    assign trib_tx_rd = tx_take ? 4'(4'h1 << tx_trib) : 4'h0;

    // value of the slot about to go out
    always_comb begin
        next_bit = trib_tx_data[tx_trib];
        unique case (tx_kind)
            // word goes out msb first; only the bit under the slot is kept
            K_ALIGN: next_bit = is_g ? 1'(`PTM_G_ALIGN >> (4'd8 - tx_bit[3:0]))
                                     : 1'(`PTM_E_ALIGN >> (4'd9 - tx_bit[3:0]));
            K_ALARM: next_bit = tx_rai;
            K_NAT: next_bit = tx_nat;
            K_PARITY: next_bit = parity_prev;
            K_ONE: next_bit = 1'b1;
            K_JCB: next_bit = stuff_now[tx_trib];
            K_STF: next_bit = stuff_now[tx_trib] ? 1'b0 : trib_tx_data[tx_trib];
            K_DAT: next_bit = trib_tx_data[tx_trib];
        endcase
    end

    // set and bit counters, first slot after reset is bit zero of set zero
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_set <= 3'd0;
            tx_bit <= 9'd0;
        end else if (tx_bit_en) begin
            if (tx_last_bit) begin
                tx_bit <= 9'd0;
                tx_set <= (tx_set == last_set) ? 3'd0 : tx_set + 3'd1;
            end else begin
                tx_bit <= tx_bit + 9'd1;
            end
        end
    end

    // interleave pointer restarts at tributary 0 in each set
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_ptr <= 2'd0;
        end else if (tx_bit_en) begin
            if (tx_last_bit) tx_ptr <= 2'd0;
            else if (tx_kind == K_DAT) tx_ptr <= (tx_ptr == last_trib) ? 2'd0 : tx_ptr + 2'd1;
        end
    end

    // stuffing requests sampled once per frame so control and slot agree
    always_ff @(posedge clk) begin
        if (rst) begin
            stuff_now <= 4'h0;
        end else if (tx_bit_en && tx_set == 3'd0 && tx_bit == 9'd0) begin
            stuff_now <= is_g ? {1'b0, trib_stuff_req[2:0]} : trib_stuff_req;
        end
    end

    // parity over tributary bits only
    always_ff @(posedge clk) begin
        if (rst) begin
            parity_acc <= 1'b0;
            parity_prev <= 1'b0;
        end else if (tx_bit_en) begin
            if (tx_last_bit && tx_set == last_set) begin
                parity_prev <= parity_acc ^ (tx_take & next_bit);
                parity_acc <= 1'b0;
            end else if (tx_take) begin
                parity_acc <= parity_acc ^ next_bit;
            end
        end
    end

    // registered line output; g747 leaves here as a plain t2-rate stream
    always_ff @(posedge clk) begin
        if (rst) begin
            line_tx_data <= 1'b0;
            line_tx_valid <= 1'b0;
            line_tx_frame_start <= 1'b0;
        end else begin
            line_tx_valid <= tx_bit_en;
            if (tx_bit_en) line_tx_data <= next_bit;
            line_tx_frame_start <= tx_bit_en && tx_set == 3'd0 && tx_bit == 9'd0;
        end
    end

    // ****************************************
    // receive deframer
    // ****************************************
    logic rx_d1, rx_d2, rx_s1, rx_s2, rx_s3; // pin synchronisers
    logic rx_en;
    ptm_rx_t rx_state;
    logic [9:0] rx_sh; // recent line bits
    logic [9:0] rx_win;
    logic [2:0] rx_set;
    logic [8:0] rx_bit;
    logic [1:0] rx_ptr;
    logic [1:0] jcb_cnt [4]; // ones seen per tributary this frame
    logic rx_parity_acc;
    logic rx_parity_prev;
    ptm_kind_t rx_kind;
    logic [1:0] rx_trib;
    logic rx_last_bit;

    // strobe is held one or more cycles; edge taken after second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            {rx_d1, rx_d2, rx_s1, rx_s2, rx_s3} <= 5'h00;
        end else begin
            rx_d1 <= line_rx_data;
            rx_d2 <= rx_d1;
            rx_s1 <= line_rx_strobe;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end
    assign rx_en = rx_s2 && !rx_s3;
    assign rx_win = {rx_sh[8:0], rx_d2};
    assign rx_kind = slot(is_g, rx_set, rx_bit);
    assign rx_last_bit = (rx_bit == set_len - 9'd1);
    always_comb begin
        rx_trib = rx_ptr;
        if (rx_kind == K_JCB) rx_trib = rx_bit[1:0];
        else if (rx_kind == K_STF) rx_trib = is_g ? 2'(rx_bit - `PTM_G_STUFF_POS) : 2'(rx_bit - `PTM_E_STUFF_POS);
    end

    // hunt for the word, then check it every frame
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_state <= RX_HUNT;
            rx_sh <= 10'h000;
            rx_set <= 3'd0;
            rx_bit <= 9'd0;
        end else if (rx_en) begin
            rx_sh <= rx_win;
            unique case (rx_state)
                RX_HUNT: begin
                    if (is_g ? rx_win[8:0] == `PTM_G_ALIGN : rx_win == `PTM_E_ALIGN) begin
                        rx_state <= RX_LOCK;
                        rx_set <= 3'd0;
                        rx_bit <= is_g ? `PTM_G_ALIGN_LEN : `PTM_E_ALIGN_LEN;
                    end
                end
                RX_LOCK: begin
                    // a broken word drops back to hunting
                    if (rx_set == 3'd0 && rx_bit == (is_g ? `PTM_G_ALIGN_LEN : `PTM_E_ALIGN_LEN) - 9'd1 &&
                        (is_g ? rx_win[8:0] != `PTM_G_ALIGN : rx_win != `PTM_E_ALIGN)) rx_state <= RX_HUNT;
                    if (rx_last_bit) begin
                        rx_bit <= 9'd0;
                        rx_set <= (rx_set == last_set) ? 3'd0 : rx_set + 3'd1;
                    end else begin
                        rx_bit <= rx_bit + 9'd1;
                    end
                end
            endcase
        end
    end
    assign rx_in_frame = (rx_state == RX_LOCK);

    // slot extraction with majority stuffing decision
    always_ff @(posedge clk) begin
        if (rst) begin
            trib_rx_data <= 4'h0;
            trib_rx_valid <= 4'h0;
            rx_ptr <= 2'd0;
            jcb_cnt <= '{default: 2'd0};
            rx_rai <= 1'b0;
            rx_nat <= 1'b0;
            rx_parity_err <= 1'b0;
            rx_parity_acc <= 1'b0;
            rx_parity_prev <= 1'b0;
        end else begin
            trib_rx_valid <= 4'h0;
            rx_parity_err <= 1'b0;
            if (rx_en && rx_state == RX_LOCK) begin
                if (rx_last_bit) rx_ptr <= 2'd0;
                else if (rx_kind == K_DAT) rx_ptr <= (rx_ptr == last_trib) ? 2'd0 : rx_ptr + 2'd1;
                if (rx_kind == K_DAT || (rx_kind == K_STF && !jcb_cnt[rx_trib][1])) begin
                    trib_rx_data[rx_trib] <= rx_d2;
                    trib_rx_valid <= 4'(4'h1 << rx_trib);
                    rx_parity_acc <= rx_parity_acc ^ rx_d2;
                end
                if (rx_kind == K_JCB && rx_d2) jcb_cnt[rx_trib] <= jcb_cnt[rx_trib] + 2'd1;
                if (rx_kind == K_ALARM) rx_rai <= rx_d2;
                if (rx_kind == K_NAT) rx_nat <= rx_d2;
                if (rx_kind == K_PARITY) rx_parity_err <= (rx_d2 != rx_parity_prev);
                if (rx_last_bit && rx_set == last_set) begin
                    jcb_cnt <= '{default: 2'd0};
                    // the closing slot of a frame is always tributary data, so fold it in here
                    rx_parity_prev <= rx_parity_acc ^ rx_d2;
                    rx_parity_acc <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    set_order_a: assert property (@(posedge clk) disable iff (rst)
        tx_bit_en && tx_last_bit |=> tx_bit == 9'd0 && tx_set == (($past(tx_set) == last_set) ? 3'd0 : $past(tx_set) + 3'd1))
        else $error("set order broken");
    frame_lead_a: assert property (@(posedge clk) disable iff (rst)
        line_tx_frame_start |-> line_tx_valid && line_tx_data) else $error("frame does not lead with word");
    jcb_value_a: assert property (@(posedge clk) disable iff (rst)
        tx_bit_en && tx_kind == K_JCB |=> line_tx_data == $past(stuff_now[tx_trib])) else $error("control bit wrong");
    stuff_skip_a: assert property (@(posedge clk) disable iff (rst)
        tx_bit_en && tx_kind == K_STF && stuff_now[tx_trib] |-> trib_tx_rd == 4'h0) else $error("stuffed slot read");
    fixed_one_a: assert property (@(posedge clk) disable iff (rst)
        tx_bit_en && is_g && tx_set == 3'd1 && tx_bit == 9'd2 |=> line_tx_data) else $error("reserved bit not one");
    rd_onehot_a: assert property (@(posedge clk) disable iff (rst)
        $onehot0(trib_tx_rd)) else $error("two tributaries read");
    g_three_trib_a: assert property (@(posedge clk) disable iff (rst)
        is_g |-> !trib_tx_rd[3]) else $error("fourth tributary read in g747");
    parity_out_a: assert property (@(posedge clk) disable iff (rst)
        tx_bit_en && tx_kind == K_PARITY |=> line_tx_data == $past(parity_prev)) else $error("parity bit wrong");
    rx_drop_a: assert property (@(posedge clk) disable iff (rst)
        rx_en && rx_in_frame && rx_kind == K_STF && jcb_cnt[rx_trib][1] |=> trib_rx_valid == 4'h0)
        else $error("stuffed slot delivered");
    e_frame_c: cover property (@(posedge clk) disable iff (rst) line_tx_frame_start && !is_g);
    g_frame_c: cover property (@(posedge clk) disable iff (rst) line_tx_frame_start && is_g);
    rx_lock_c: cover property (@(posedge clk) disable iff (rst) $rose(rx_in_frame));
endmodule

//--- ptm_pkg.sv
// shared types for the tributary multiplexer
package ptm_pkg;
    // framing selected for one stage
    typedef enum logic [1:0] {
        PTM_FIRST_SECOND = 2'b00,
        PTM_SECOND_THIRD = 2'b01,
        PTM_G747 = 2'b10
    } ptm_mode_t;
    // meaning of one line bit slot
    typedef enum logic [2:0] {
        K_ALIGN = 3'b000,
        K_ALARM = 3'b001,
        K_NAT = 3'b010,
        K_PARITY = 3'b011,
        K_ONE = 3'b100,
        K_JCB = 3'b101,
        K_STF = 3'b110,
        K_DAT = 3'b111
    } ptm_kind_t;
    // receive alignment state
    typedef enum logic {
        RX_HUNT = 1'b0,
        RX_LOCK = 1'b1
    } ptm_rx_t;
endpackage

//--- test_ptm_mux.sv
// self-checking bench for the tributary multiplexer, transmit checked bit by bit, receive by loopback
`timescale 1ns/1ps
module test_ptm_mux;
    import ptm_pkg::*;
    localparam logic [9:0] align_e = 10'h3d0; // ten-bit alignment word
    localparam logic [8:0] align_g = 9'h1d0; // nine-bit alignment word
    logic clk = 1'b0;
    logic rst = 1'b1;
    ptm_mode_t mode = PTM_FIRST_SECOND;
    logic tx_bit_en = 1'b0, tx_rai = 1'b0, tx_nat = 1'b0;
    logic [3:0] trib_stuff_req = 4'h0, trib_tx_data = 4'h0;
    logic [3:0] trib_tx_rd, trib_rx_data, trib_rx_valid;
    logic line_tx_data, line_tx_valid, line_tx_frame_start, line_rx_data, line_rx_strobe, busy;
    logic rx_in_frame, rx_rai, rx_nat, rx_parity_err;
    int n_errors = 0, compares = 0;
    int s, b, ptr, frames; // reference frame position
    logic [3:0] stf; // stuffing requests latched for this frame
    logic parity_now, parity_acc, pend, pbit, pfs;
    logic sent [4][$]; // tributary bits still owed by the receiver
    ptm_mux u_dut (.clk(clk), .rst(rst), .mode(mode), .tx_bit_en(tx_bit_en), .tx_rai(tx_rai), .tx_nat(tx_nat),
        .trib_stuff_req(trib_stuff_req), .trib_tx_data(trib_tx_data), .trib_tx_rd(trib_tx_rd),
        .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid), .line_tx_frame_start(line_tx_frame_start),
        .line_rx_data(line_rx_data), .line_rx_strobe(line_rx_strobe), .trib_rx_data(trib_rx_data),
        .trib_rx_valid(trib_rx_valid), .rx_in_frame(rx_in_frame), .rx_rai(rx_rai), .rx_nat(rx_nat),
        .rx_parity_err(rx_parity_err));
    ptm_line_model u_line (.clk(clk), .rst(rst), .tx_data(line_tx_data), .tx_valid(line_tx_valid),
        .rx_data(line_rx_data), .rx_strobe(line_rx_strobe), .busy(busy));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // ****************************************
    // compare tasks and reference
    // ****************************************
    task automatic chk_line(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_trib(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: strobes got %h expected %h", $time, got, exp);
        end
    endtask
    // meaning of slot b of set s; t is the tributary of a control or stuffing slot
    function automatic ptm_kind_t kind_of(input ptm_mode_t m, input int s, input int b, output int t);
        bit g;
        g = (m == PTM_G747);
        t = g ? b - 3 : b - 4;
        if (s == 0) begin
            if (b < (g ? 9 : 10)) return K_ALIGN;
            if (!g && b == 10) return K_ALARM;
            if (!g && b == 11) return K_NAT;
            return K_DAT;
        end
        if (g && s == 1) return (b == 0) ? K_ALARM : (b == 1) ? K_PARITY : (b == 2) ? K_ONE : K_DAT;
        if (b < (g ? 3 : 4)) begin
            t = b;
            return K_JCB;
        end
        if (s == (g ? 4 : 3) && b < (g ? 6 : 8)) return K_STF;
        return K_DAT;
    endfunction
    // one cycle: check last bit, drive the next, predict strobes and line bit
    task automatic step(input logic en);
        int t;
        ptm_kind_t k;
        logic [3:0] rd;
        logic bv;
        bit g;
        g = (mode == PTM_G747);
        @(negedge clk);
        chk_line(line_tx_valid, pend);
        if (pend) chk_line(line_tx_data, pbit);
        chk_line(line_tx_frame_start, pend && pfs);
        tx_bit_en = en;
        trib_tx_data = 4'($urandom);
        if (en && s == 0 && b == 0) begin
            // corner requests first: none stuffed, then all stuffed
            trib_stuff_req = (frames == 0) ? 4'h0 : (frames == 1) ? 4'hf : 4'($urandom);
            stf = trib_stuff_req;
            parity_now = parity_acc;
            parity_acc = 1'b0;
        end
        #1;
        rd = 4'h0;
        bv = 1'b0;
        pfs = en && s == 0 && b == 0;
        if (en) begin
            k = kind_of(mode, s, b, t);
            if (k == K_DAT) begin
                t = ptr;
                ptr = (ptr + 1) % (g ? 3 : 4);
            end
            case (k)
                K_ALIGN: bv = g ? align_g[8 - b] : align_e[9 - b];
                K_ALARM: bv = tx_rai;
                K_NAT: bv = tx_nat;
                K_PARITY: bv = parity_now;
                K_ONE: bv = 1'b1;
                K_JCB: bv = stf[t];
                default: begin
                    if (k == K_DAT || !stf[t]) begin
                        rd[t] = 1'b1;
                        bv = trib_tx_data[t];
                        sent[t].push_back(bv);
                        parity_acc ^= bv;
                    end
                end
            endcase
            b++;
            if (b == (g ? 168 : (mode == PTM_SECOND_THIRD) ? 384 : 212)) begin
                b = 0;
                ptr = 0;
                s++;
                if (s == (g ? 5 : 4)) begin
                    s = 0;
                    frames++;
                end
            end
        end
        chk_trib(trib_tx_rd, rd);
        pend = en;
        pbit = bv;
    endtask
    // receive side must return every tributary bit in order, stuffing included
    always @(negedge clk) begin
        for (int j = 0; j < 4; j++) begin
            if (trib_rx_valid[j] === 1'b1) begin
                chk_line(trib_rx_data[j], sent[j].size() != 0 ? sent[j].pop_front() : ~trib_rx_data[j]);
            end
        end
        // a clean loopback never shows a parity mismatch
        chk_line(rx_parity_err, 1'b0);
    end
    // ****************************************
    // test sequence
    // ****************************************
    task automatic run_mode(input ptm_mode_t m);
        int n;
        @(negedge clk);
        rst = 1'b1;
        tx_bit_en = 1'b0;
        mode = m;
        tx_rai = 1'($urandom);
        tx_nat = 1'($urandom);
        repeat (16) @(negedge clk);
        for (int j = 0; j < 4; j++) sent[j].delete();
        {s, b, ptr, frames} = '0;
        {parity_now, parity_acc, pend} = 3'h0;
        rst = 1'b0;
        // the second frame is sent back to back
        while (frames < 3) step(($urandom_range(0, 2) != 0) || frames == 1);
        n = 0;
        while ((busy !== 1'b0 || n < 20) && n < 30000) begin
            step(1'b0);
            n = (busy === 1'b0) ? n + 1 : 0;
        end
        chk_line(rx_in_frame, 1'b1);
        chk_line(rx_rai, tx_rai);
        if (m != PTM_G747) chk_line(rx_nat, tx_nat);
        chk_trib({sent[3].size() != 0, sent[2].size() != 0, sent[1].size() != 0, sent[0].size() != 0}, 4'h0);
        $display("test of mode %0d done", m);
    endtask
    task automatic finish_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h85a9));
        run_mode(PTM_FIRST_SECOND);
        run_mode(PTM_SECOND_THIRD);
        run_mode(PTM_G747);
        finish_test();
    end
    // watchdog: the whole run needs about 39000 cycles
    initial begin
        #450000;
        n_errors++;
        $display("Error at %0t: run timed out", $time);
        finish_test();
    end
endmodule
